// >>> logic/balu_defs.svh
// Constants for the byte ALU: register map, field positions, reset values.
//
// Behaviour
// - XOR accumulator with byte; zero flag only.
// - Flat address reaches every data byte.
// - Add with carry; all five arithmetic flags.
// - Add without carry; all five arithmetic flags.
// - AND to chosen destination; zero flag only.
// - OR to chosen destination; zero flag only.
// - Clear byte to zero, flags untouched.
// - Clear one selected bit, flags untouched.
// - Invert byte, chosen destination, zero flag.
// - Decimal adjust nibbles, result to memory.
// - Decimal adjust touches carry flag only.
// - Decrement byte, chosen destination, zero flag.
// - Increment byte, chosen destination, zero flag.
// - Copy byte either way, flags untouched.
// - Rotate left, top bit wraps, no flags.
// - Rotate left through carry, carry only.
// - Rotate right, bottom bit wraps, no flags.
// - Rotate right through carry, carry only.
// - Accumulator destination leaves memory byte unchanged.
`ifndef BALU_DEFS_SVH
`define BALU_DEFS_SVH

// Byte offsets of the software-visible registers.
`define BALU_OFS_ACC 8'h00
`define BALU_OFS_FLAGS 8'h04
`define BALU_OFS_ADDR 8'h08
`define BALU_OFS_DATA 8'h0C
`define BALU_OFS_CMD 8'h10
`define BALU_OFS_IMM 8'h14

// Flag bit positions within the flag register.
`define BALU_FLG_C 0
`define BALU_FLG_HALF_NIBBLE 1
`define BALU_FLG_Z 2
`define BALU_FLG_SIGNED_RANGE 3
`define BALU_FLG_SECONDARY_WRAP 4
`define BALU_FLG_W 5

// Command word fields.
`define BALU_CMD_OP_HI 4
`define BALU_CMD_ACC 5
`define BALU_CMD_BIT_HI 8
`define BALU_CMD_BIT_LO 6

// Reset values and decimal adjust constants.
`define BALU_RST_BYTE 8'h00
`define BALU_RST_FLAGS 5'h00
`define BALU_DEC_LIMIT 4'h9
`define BALU_DEC_LO_ADJ 8'h06
`define BALU_DEC_HI_ADJ 8'h60

`endif

// >>> logic/balu_pkg.sv
// Types shared by the byte ALU: the operation codes.
package balu_pkg;

    // Operation codes carried in the low bits of the command word.
    typedef enum logic [4:0] {
        xor_with_mem = 5'h00,
        xor_with_imm = 5'h01,
        ext_add_with_wrap = 5'h02,
        ext_add_plain = 5'h03,
        ext_bitwise_conj = 5'h04,
        ext_bitwise_disj = 5'h05,
        ext_zero_fill = 5'h06,
        ext_zero_fill_bit = 5'h07,
        ext_invert = 5'h08,
        ext_decimal_adjust = 5'h09,
        ext_count_down = 5'h0A,
        ext_count_up = 5'h0B,
        ext_copy = 5'h0C,
        ext_rotate_left = 5'h0D,
        ext_rotate_left_thru_wrap = 5'h0E,
        ext_rotate_right = 5'h0F,
        ext_rotate_right_thru_wrap = 5'h10
    } balu_op_t;

endpackage : balu_pkg

// >>> logic/balu_top.sv
// Byte ALU datapath with flat data memory, reached over an Avalon-MM slave.
//
// Local design decisions: the address map and the Avalon-MM register port.
`include "balu_defs.svh"

module balu_top #(
    parameter int ADDR_W = 12,
    parameter int DEPTH = 2304
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // Zero test shared by every operation that reports the zero flag.
    function automatic logic balu_is_zero(input logic [7:0] v);
        balu_is_zero = (v == 8'h00);
    endfunction : balu_is_zero

    logic [7:0] acc_q; // Accumulator.
    logic [`BALU_FLG_W-1:0] flags_q; // Status flags.
    logic [ADDR_W-1:0] addr_q; // Flat data memory address, no banking.
    logic [7:0] imm_q; // Immediate operand.
    logic [7:0] mem_q [DEPTH]; // Data memory, every section in one array.
    logic waitreq_q; // Registered waitrequest.
    logic [31:0] rdata_q; // Registered read data.

    // Bus decode.
    wire bus_req = avs_read | avs_write;
    wire fire = bus_req & ~waitreq_q;
    wire wr_fire = fire & avs_write;
    wire be0 = avs_byteenable[0];
    wire sel_acc = (avs_address == `BALU_OFS_ACC);
    wire sel_flags = (avs_address == `BALU_OFS_FLAGS);
    wire sel_addr = (avs_address == `BALU_OFS_ADDR);
    wire sel_data = (avs_address == `BALU_OFS_DATA);
    wire sel_cmd = (avs_address == `BALU_OFS_CMD);
    wire sel_imm = (avs_address == `BALU_OFS_IMM);

    // Command fields, taken straight from the write data of a command write.
    wire [4:0] cmd_op = avs_writedata[`BALU_CMD_OP_HI:0];
    wire cmd_acc = avs_writedata[`BALU_CMD_ACC];
    wire [2:0] bit_sel = avs_writedata[`BALU_CMD_BIT_HI:`BALU_CMD_BIT_LO];
    wire balu_pkg::balu_op_t cur_op = balu_pkg::balu_op_t'(cmd_op);
    wire exec = wr_fire & sel_cmd & be0;

    // Addresses past the end of the array read as zero and ignore writes.
    wire addr_ok = (32'(addr_q) < DEPTH);
    wire [7:0] mem_rd = addr_ok ? mem_q[addr_q] : 8'h00;
    wire mem_top = mem_rd[7];
    wire [7:0] bit_mask = 8'h01 << bit_sel;

    // Adder shared by both add forms; carry-in only for the carry form.
    wire cin = (cur_op == balu_pkg::ext_add_with_wrap) & flags_q[`BALU_FLG_C];
    wire [8:0] sum9 = {1'b0, acc_q} + {1'b0, mem_rd} + {8'h00, cin};
    wire [4:0] half5 = {1'b0, acc_q[3:0]} + {1'b0, mem_rd[3:0]} + {4'h0, cin};
    wire add_c = sum9[8];
    wire add_h = half5[4];
    wire add_ov = (acc_q[7] == mem_rd[7]) & (sum9[7] != acc_q[7]);

    // Decimal adjust decisions look at the accumulator before adjustment.
    wire daa_lo = (acc_q[3:0] > `BALU_DEC_LIMIT) | flags_q[`BALU_FLG_HALF_NIBBLE];
    wire daa_hi = (acc_q[7:4] > `BALU_DEC_LIMIT) | flags_q[`BALU_FLG_C];
    wire [7:0] daa_adj = (daa_lo ? `BALU_DEC_LO_ADJ : `BALU_RST_BYTE)
        | (daa_hi ? `BALU_DEC_HI_ADJ : `BALU_RST_BYTE);
    wire [8:0] daa_sum = {1'b0, acc_q} + {1'b0, daa_adj};
    // Carry is only ever raised, so a chained decimal add keeps its carry.
    wire daa_c = daa_sum[8] | daa_hi;

    // Flags other than carry, watched to prove they stay put.
    wire [`BALU_FLG_W-2:0] flags_rest = flags_q[`BALU_FLG_W-1:1];

    logic [7:0] res; // Operation result.
    logic [`BALU_FLG_W-1:0] flags_n; // Flags after the operation.
    logic dst_acc; // Result goes to the accumulator.
    logic op_ok; // Code is a known operation.

    // Result, destination and flags for the operation in the command word.
    always_comb
    begin
        res = acc_q;
        flags_n = flags_q;
        dst_acc = cmd_acc;
        op_ok = 1'b1;
        unique case (cur_op)
            balu_pkg::xor_with_mem:
            begin
                res = acc_q ^ mem_rd;
                flags_n[`BALU_FLG_Z] = balu_is_zero(res);
            end
            balu_pkg::xor_with_imm:
            begin
                // The immediate form always lands in the accumulator.
                res = acc_q ^ imm_q;
                dst_acc = 1'b1;
                flags_n[`BALU_FLG_Z] = balu_is_zero(res);
            end
            balu_pkg::ext_add_with_wrap, balu_pkg::ext_add_plain:
            begin
                res = sum9[7:0];
                flags_n[`BALU_FLG_C] = add_c;
                flags_n[`BALU_FLG_HALF_NIBBLE] = add_h;
                flags_n[`BALU_FLG_SIGNED_RANGE] = add_ov;
                // Secondary carry holds the true sign of the wide result.
                flags_n[`BALU_FLG_SECONDARY_WRAP] = add_ov ^ sum9[7];
                flags_n[`BALU_FLG_Z] = balu_is_zero(res);
            end
            balu_pkg::ext_bitwise_conj:
            begin
                res = acc_q & mem_rd;
                flags_n[`BALU_FLG_Z] = balu_is_zero(res);
            end
            balu_pkg::ext_bitwise_disj:
            begin
                res = acc_q | mem_rd;
                flags_n[`BALU_FLG_Z] = balu_is_zero(res);
            end
            balu_pkg::ext_zero_fill:
            begin
                res = `BALU_RST_BYTE;
                dst_acc = 1'b0;
            end
            balu_pkg::ext_zero_fill_bit:
            begin
                res = mem_rd & ~bit_mask;
                dst_acc = 1'b0;
            end
            balu_pkg::ext_invert:
            begin
                res = ~mem_rd;
                flags_n[`BALU_FLG_Z] = balu_is_zero(res);
            end
            balu_pkg::ext_decimal_adjust:
            begin
                res = daa_sum[7:0];
                dst_acc = 1'b0;
                flags_n[`BALU_FLG_C] = daa_c;
            end
            balu_pkg::ext_count_down:
            begin
                res = mem_rd - 8'h01;
                flags_n[`BALU_FLG_Z] = balu_is_zero(res);
            end
            balu_pkg::ext_count_up:
            begin
                res = mem_rd + 8'h01;
                flags_n[`BALU_FLG_Z] = balu_is_zero(res);
            end
            balu_pkg::ext_copy:
            begin
                // The destination bit picks the direction of the copy.
                res = cmd_acc ? mem_rd : acc_q;
            end
            balu_pkg::ext_rotate_left:
            begin
                res = {mem_rd[6:0], mem_rd[7]};
            end
            balu_pkg::ext_rotate_left_thru_wrap:
            begin
                res = {mem_rd[6:0], flags_q[`BALU_FLG_C]};
                flags_n[`BALU_FLG_C] = mem_rd[7];
            end
            balu_pkg::ext_rotate_right:
            begin
                res = {mem_rd[0], mem_rd[7:1]};
            end
            balu_pkg::ext_rotate_right_thru_wrap:
            begin
                res = {flags_q[`BALU_FLG_C], mem_rd[7:1]};
                flags_n[`BALU_FLG_C] = mem_rd[0];
            end
            default:
            begin
                // Unknown codes do nothing at all.
                op_ok = 1'b0;
                dst_acc = 1'b0;
            end
        endcase
    end

    wire run = exec & op_ok;
    wire wr_acc = run & dst_acc;
    // An accumulator destination never writes memory.
    wire wr_mem = run & ~dst_acc & addr_ok;

    // Read data mux; unmapped offsets read as zero.
    wire [31:0] rd_mux = sel_acc ? {24'h000000, acc_q}
        : sel_flags ? {27'h0000000, flags_q}
        : sel_addr ? 32'(addr_q)
        : sel_data ? {24'h000000, mem_rd}
        : sel_imm ? {24'h000000, imm_q}
        : 32'h00000000;

    // One wait cycle per access keeps the slave simple and the timing fixed.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            waitreq_q <= 1'b1;
        else
            waitreq_q <= ~(bus_req & waitreq_q);
    end

    // Read data is captured in the wait cycle and stands at the answer edge.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            rdata_q <= 32'h00000000;
        else if (avs_read & waitreq_q)
            rdata_q <= rd_mux;
    end

    // Accumulator: bus write or operation result.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            acc_q <= `BALU_RST_BYTE;
        else if (wr_acc)
            acc_q <= res;
        else if (wr_fire & sel_acc & be0)
            acc_q <= avs_writedata[7:0];
    end

    // Flags: an operation has priority over a software write.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            flags_q <= `BALU_RST_FLAGS;
        else if (run)
            flags_q <= flags_n;
        else if (wr_fire & sel_flags & be0)
            flags_q <= avs_writedata[`BALU_FLG_W-1:0];
    end

    // Address and immediate registers; the address spans two byte lanes.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            addr_q <= '0;
            imm_q <= `BALU_RST_BYTE;
        end
        else
        begin
            if (wr_fire & sel_addr & (avs_byteenable[1:0] == 2'h3))
                addr_q <= avs_writedata[ADDR_W-1:0];
            if (wr_fire & sel_imm & be0)
                imm_q <= avs_writedata[7:0];
        end
    end

    // Data memory write port; no reset, as on a real RAM.
    always_ff @(posedge core_clk)
    begin
        if (wr_mem)
            mem_q[addr_q] <= res;
        else if (wr_fire & sel_data & be0 & addr_ok)
            mem_q[addr_q] <= avs_writedata[7:0];
    end

    assign avs_waitrequest = waitreq_q;
    assign avs_readdata = rdata_q;

    default clocking balu_cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_run(balu_pkg::balu_op_t o);
        run && cur_op == o;
    endsequence

    sequence s_to_acc(balu_pkg::balu_op_t o);
        s_run(o) ##0 dst_acc;
    endsequence

    // A memory destination only lands when the flat address is inside the array.
    sequence s_to_mem(balu_pkg::balu_op_t o);
        s_run(o) ##0 !dst_acc ##0 addr_ok;
    endsequence

    a_xor_into_acc: assert property (s_to_acc(balu_pkg::xor_with_mem) |=>
        acc_q == ($past(acc_q) ^ $past(mem_rd)) && flags_q[`BALU_FLG_Z] == (acc_q == 8'h00))
        else $error("xor result or zero flag wrong");
    a_flat_write: assert property (wr_mem |=> mem_rd == $past(res))
        else $error("memory byte not written");
    a_adc_sum: assert property (s_to_acc(balu_pkg::ext_add_with_wrap) |=>
        {flags_q[`BALU_FLG_C], acc_q} == $past(sum9))
        else $error("add with carry result wrong");
    a_add_flags: assert property (s_run(balu_pkg::ext_add_plain) |=>
        flags_q[`BALU_FLG_C] == $past(add_c) && flags_q[`BALU_FLG_HALF_NIBBLE] == $past(add_h)
        && flags_q[`BALU_FLG_SIGNED_RANGE] == $past(add_ov))
        else $error("add carry flags wrong");
    a_clr_quiet: assert property (s_run(balu_pkg::ext_zero_fill) |=>
        $stable(flags_q) && (mem_rd == 8'h00))
        else $error("clear changed flags or left bits");
    a_clr_bit_mask: assert property (s_run(balu_pkg::ext_zero_fill_bit) |=>
        mem_rd == ($past(mem_rd) & ~$past(bit_mask)))
        else $error("bit clear touched other bits");
    a_daa_carry_only: assert property (s_run(balu_pkg::ext_decimal_adjust) |=>
        flags_q[`BALU_FLG_C] == $past(daa_c) && $stable(flags_rest))
        else $error("decimal adjust flags wrong");
    a_rlc_carry: assert property (s_run(balu_pkg::ext_rotate_left_thru_wrap) |=>
        flags_q[`BALU_FLG_C] == $past(mem_top) && $stable(flags_rest))
        else $error("rotate through carry flag wrong");
    a_add_plain_sum: assert property (s_to_acc(balu_pkg::ext_add_plain) |=>
        acc_q == $past(acc_q) + $past(mem_rd))
        else $error("plain add result wrong");
    a_and_into_acc: assert property (s_to_acc(balu_pkg::ext_bitwise_conj) |=>
        acc_q == ($past(acc_q) & $past(mem_rd)))
        else $error("and result wrong");
    a_or_into_mem: assert property (s_to_mem(balu_pkg::ext_bitwise_disj) |=>
        mem_rd == ($past(acc_q) | $past(mem_rd)))
        else $error("or result wrong");
    a_invert_mem: assert property (s_to_mem(balu_pkg::ext_invert) |=>
        mem_rd == ~$past(mem_rd))
        else $error("complement result wrong");
    a_decimal_to_mem: assert property (s_to_mem(balu_pkg::ext_decimal_adjust) |=>
        mem_rd == $past(acc_q) + ($past(daa_lo) ? `BALU_DEC_LO_ADJ : `BALU_RST_BYTE)
        + ($past(daa_hi) ? `BALU_DEC_HI_ADJ : `BALU_RST_BYTE))
        else $error("decimal adjust result wrong");
    a_count_down: assert property (s_to_mem(balu_pkg::ext_count_down) |=>
        mem_rd == $past(mem_rd) - 8'h01)
        else $error("decrement result wrong");
    a_count_up: assert property (s_to_acc(balu_pkg::ext_count_up) |=>
        acc_q == $past(mem_rd) + 8'h01)
        else $error("increment result wrong");
    a_copy_quiet: assert property (s_run(balu_pkg::ext_copy) |=> $stable(flags_q))
        else $error("copy changed a flag");
    a_rotate_left: assert property (s_to_mem(balu_pkg::ext_rotate_left) |=>
        mem_rd == {$past(mem_rd[6:0]), $past(mem_top)} && $stable(flags_q))
        else $error("rotate left result wrong");
    a_rotate_right: assert property (s_to_acc(balu_pkg::ext_rotate_right) |=>
        acc_q == {$past(mem_rd[0]), $past(mem_rd[7:1])} && $stable(flags_q))
        else $error("rotate right result wrong");
    a_rrc_carry: assert property (s_run(balu_pkg::ext_rotate_right_thru_wrap) |=>
        flags_q[`BALU_FLG_C] == $past(mem_rd[0]) && $stable(flags_rest))
        else $error("rotate right through carry flag wrong");
    a_imm_zero: assert property (s_run(balu_pkg::xor_with_imm) |=>
        acc_q == ($past(acc_q) ^ $past(imm_q)) && flags_q[`BALU_FLG_Z] == (acc_q == 8'h00))
        else $error("immediate xor result or zero flag wrong");
    a_acc_keeps_mem: assert property (run && dst_acc |=> $stable(mem_rd))
        else $error("accumulator variant wrote memory");
    a_bus_answer: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("slave did not answer in one cycle");

endmodule : balu_top

// >>> tb/balu_host_model.sv
// Avalon-MM host model standing in for the core's instruction decoder.
module balu_host_model (
    input wire logic core_clk,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    output logic [7:0] avs_address,
    output logic [3:0] avs_byteenable,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus is idle at time zero, and every byte lane is always enabled.
    initial
    begin
        avs_address = 8'h00;
        avs_byteenable = 4'hF;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end

    // One access: hold the request until waitrequest is sampled low, then release it.
    // The trailing idle edge keeps back-to-back calls from driving a strobe twice in one step.
    task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        rdata = 32'h0;
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_write <= wr;
        avs_read <= !wr;
        // The bound stops a dead slave from hanging the run.
        while (!ok && n < 16)
        begin
            @(posedge core_clk);
            n++;
            if (avs_waitrequest === 1'b0)
            begin
                ok = 1'b1;
                rdata = avs_readdata;
            end
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask : access

endmodule : balu_host_model

// >>> tb/byte_alu_extended_ops_tb_top.sv
// Self-checking bench for the byte ALU: runs every operation over the register bus.
`include "balu_defs.svh"

module byte_alu_extended_ops_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk; // Core clock, 40 MHz.
    logic nrst; // Synchronous reset, active low.
    logic [7:0] avs_address;
    logic [3:0] avs_byteenable;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int miscompares; // Mismatches and hangs so far.
    int tests_run; // Comparisons made so far.
    // Operand sets chosen for carry chains, signed overflow, decimal adjust and wrap to zero.
    logic [7:0] va [4] = '{8'h00, 8'h7F, 8'h9A, 8'hFE};
    logic [7:0] vm [4] = '{8'hFF, 8'h01, 8'h88, 8'h01};
    logic [4:0] vf [4] = '{5'h1F, 5'h00, 5'h02, 5'h01};
    // Flat addresses spread over several sections, the last byte included.
    logic [11:0] vaddr [4] = '{12'h8FF, 12'h480, 12'h123, 12'h0FF};

    // Free-running clock with a 25 ns period.
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    balu_top u_balu_top (
        .core_clk(core_clk),
        .nrst(nrst),
        .avs_address(avs_address),
        .avs_byteenable(avs_byteenable),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );

    balu_host_model u_balu_host_model (
        .core_clk(core_clk),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .avs_address(avs_address),
        .avs_byteenable(avs_byteenable),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata)
    );

    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    // Compares one byte-wide result.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    // One bus access; a slave that never answers counts as a mismatch and ends the run.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        logic ok;
        u_balu_host_model.access(w, a, wd, rd, ok);
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("[FAIL] %0t bus access timed out", $time);
            stop_test();
        end
    endtask : bus

    // Reference behaviour of one operation on accumulator, flags and memory byte.
    function automatic void ref_op(input logic [4:0] op, input logic ta, input logic [2:0] bi,
        input logic [7:0] imm, inout logic [7:0] a, inout logic [4:0] f, inout logic [7:0] m);
        logic [8:0] s;
        logic [4:0] h;
        logic [8:0] d9;
        logic [7:0] r;
        logic cin;
        logic lo;
        logic hi;
        cin = (op == 5'h02) & f[0];
        s = {1'b0, a} + {1'b0, m} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
        lo = (a[3:0] > 4'h9) | f[1];
        hi = (a[7:4] > 4'h9) | f[0];
        d9 = {1'b0, a} + (hi ? 9'h060 : 9'h000) + (lo ? 9'h006 : 9'h000);
        case (op)
            5'h00: r = a ^ m;
            5'h01: r = a ^ imm;
            5'h02, 5'h03: r = s[7:0];
            5'h04: r = a & m;
            5'h05: r = a | m;
            5'h06: r = 8'h00;
            5'h07: r = m & ~(8'h01 << bi);
            5'h08: r = ~m;
            5'h09: r = d9[7:0];
            5'h0A: r = m - 8'h01;
            5'h0B: r = m + 8'h01;
            5'h0C: r = ta ? m : a;
            5'h0D: r = {m[6:0], m[7]};
            5'h0E: r = {m[6:0], f[0]};
            5'h0F: r = {m[0], m[7:1]};
            5'h10: r = {f[0], m[7:1]};
            default: return;
        endcase
        // Flags are worked out from the old operands before any destination changes.
        if (op inside {5'h02, 5'h03})
        begin
            f[0] = s[8];
            f[1] = h[4];
            f[3] = (a[7] == m[7]) && (r[7] != a[7]);
            f[4] = f[3] ^ r[7];
        end
        if (op inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h08, 5'h0A, 5'h0B})
            f[2] = (r == 8'h00);
        if (op == 5'h09)
            f[0] = f[0] | d9[8] | hi;
        if (op inside {5'h0E, 5'h10})
            f[0] = (op == 5'h0E) ? m[7] : m[0];
        if (op == 5'h01 || (ta && !(op inside {5'h06, 5'h07, 5'h09})))
            a = r;
        else
            m = r;
    endfunction : ref_op

    // Loads operands, issues one command, then checks accumulator, flags and memory byte.
    task automatic run_op(input logic [4:0] op, input logic ta, input int k);
        logic [7:0] a;
        logic [7:0] m;
        logic [7:0] i;
        logic [4:0] f;
        logic [2:0] bi;
        logic [31:0] d;
        a = va[k];
        m = vm[k];
        f = vf[k];
        i = ~vm[k];
        bi = 3'(op + k);
        bus(1'b1, `BALU_OFS_ACC, {24'h0, a}, d);
        bus(1'b1, `BALU_OFS_FLAGS, {27'h0, f}, d);
        bus(1'b1, `BALU_OFS_ADDR, {20'h0, vaddr[k]}, d);
        bus(1'b1, `BALU_OFS_DATA, {24'h0, m}, d);
        bus(1'b1, `BALU_OFS_IMM, {24'h0, i}, d);
        bus(1'b1, `BALU_OFS_CMD, {23'h0, bi, ta, op}, d);
        ref_op(op, ta, bi, i, a, f, m);
        bus(1'b0, `BALU_OFS_ACC, 32'h0, d);
        chk8(d[7:0], a);
        bus(1'b0, `BALU_OFS_FLAGS, 32'h0, d);
        chk8({3'h0, d[4:0]}, {3'h0, f});
        bus(1'b0, `BALU_OFS_DATA, 32'h0, d);
        chk8(d[7:0], m);
    endtask : run_op

    // Main sequence: reset, register defaults, address bounds, then every operation.
    initial
    begin
        logic [31:0] d;
        miscompares = 0;
        tests_run = 0;
        nrst = 1'b0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        // Registers come out of reset cleared; memory is skipped since it is not reset.
        for (int r = 0; r < 7; r++)
        begin
            if (r == 3)
                continue;
            bus(1'b0, 8'(r * 4), 32'h0, d);
            chk8(d[7:0], 8'h00);
        end
        // A sentinel byte at flat address zero, which no operand set uses.
        bus(1'b1, `BALU_OFS_ADDR, 32'h0, d);
        bus(1'b1, `BALU_OFS_DATA, 32'h5A, d);
        // A flat address past the last byte holds nothing.
        bus(1'b1, `BALU_OFS_ADDR, 32'h900, d);
        bus(1'b1, `BALU_OFS_DATA, 32'h77, d);
        bus(1'b0, `BALU_OFS_DATA, 32'h0, d);
        chk8(d[7:0], 8'h00);
        // Every defined code plus one unused code, with both destinations.
        for (int k = 0; k < 4; k++)
            for (int o = 0; o <= 17; o++)
                for (int t = 0; t < 2; t++)
                    run_op(5'(o), t[0], k);
        bus(1'b1, `BALU_OFS_ADDR, 32'h0, d);
        bus(1'b0, `BALU_OFS_DATA, 32'h0, d);
        chk8(d[7:0], 8'h5A);
        stop_test();
    end

endmodule : byte_alu_extended_ops_tb_top
